// [rtl/program_sequencer.v]
// Purpose: Program counter, four-phase cycle, fetch pipeline, table lookup and stack.
// Assumes: Core decodes instructions and presents an operation per cycle.
// Notes:   Program memory read is one clock, registered in phase 3.
`include "seq_defines.vh"
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Four phases make one instruction cycle.
// - Fetch overlaps execute; transfers cost dummy cycle.
// - Counter advances by one after each fetch.
// - Met skip discards prefetch for dummy cycle.
// - Low byte at 06H; write short-jumps.
// - Program memory 2048 words of 14 bits.
// - Counter and stack entries are 11 bits.
// - Reset loads counter with 000H.
// - Comparator interrupts vector to 004H, 008H.
// - External pin falling edge vectors to 00CH.
// - First timer overflow vectors to 010H.
// - Second timer overflow vectors to 014H.
// - Conversion end vectors to 018H.
// - Current-page lookup uses upper counter bits.
// - Final-page lookup; low byte to data.
// - High bits to 08H; top two zero.
// - Pointer read/write at 07H; 08H read-only.
// - Table reads take two instruction cycles.
// - Eight hidden levels storing counter values only.
// - Call/interrupt pushes; returns pop into counter.
// - Reset leaves stack pointer at empty top.
// - Full stack holds interrupts until a return.
// - Call when full overwrites oldest entry.
module program_sequencer
(
  input  wire        CLK,          // System clock, 50 MHz.
  input  wire        RESET,        // Asynchronous reset, active high.
  input  wire [2:0]  OP,           // Operation of executing instruction.
  input  wire [10:0] OP_TARGET,    // Jump or call target address.
  input  wire        SKIP_MET,     // Skip condition of a skip operation is true.
  input  wire [7:0]  TAB_DEST,     // Data address receiving lookup low byte.
  input  wire [7:0]  DATA_ADDR,    // Data memory bus address.
  input  wire [7:0]  DATA_WDATA,   // Data memory bus write data.
  input  wire        DATA_WE,      // Data write strobe, phase 3 of a cycle.
  input  wire [5:0]  INT_REQ,      // Enabled pending interrupt requests.
  input  wire [13:0] ROM_DATA,     // Program memory read data.
  output reg  [10:0] ROM_ADDR,     // Program memory address.
  output reg  [13:0] INSTR,        // Fetched instruction for execution.
  output reg         INSTR_VALID,  // Low when current slot is a dummy cycle.
  output reg  [1:0]  PHASE,        // Current phase, 0 to 3.
  output reg  [7:0]  DATA_RDATA,   // Read data for 06H, 07H, 08H.
  output reg         TAB_WE,       // Pulse writing lookup low byte.
  output reg  [7:0]  TAB_WADDR,    // Destination of lookup low byte.
  output reg  [7:0]  TAB_WDATA,    // Lookup low byte.
  output reg  [5:0]  INT_ACK       // One-hot acknowledge, one clock.
);
  reg  [1:0]  phase_q;       // Phase counter.
  reg  [10:0] pc_q;          // Program counter.
  reg  [7:0]  lookup_ptr_q;  // Lookup pointer at 07H.
  reg  [5:0]  lookup_hi_q;   // Lookup high result, six live bits.
  reg         dummy_q;       // Next execute slot is a dummy.
  reg         tab_pend_q;    // Table fetch happens in the dummy cycle.
  reg  [10:0] tab_addr_q;    // Table word address.
  reg  [7:0]  tab_dest_q;    // Saved destination address.
  wire [10:0] stack_top;
  wire        stack_full;
  reg         push;
  reg         pop;
  reg  [10:0] pc_d;
  reg         dummy_d;
  reg  [5:0]  ack_d;
  reg  [10:0] vec;

  localparam [1:0] PH_FETCH = 2'h0;  // Address presented.
  localparam [1:0] PH_EXEC  = 2'h3;  // Last phase: commit.

  // Priority pick: lowest vector first among requests.
  function [5:0] pick_lowest;
    input [5:0] req;
    begin
      pick_lowest = req & (~req + 6'h01);
    end
  endfunction

  // Vector from a one-hot acknowledge.
  function [10:0] vector_of;
    input [5:0] ack;
    begin
      case (ack)
        6'h01:   vector_of = `VEC_CMP0;
        6'h02:   vector_of = `VEC_CMP1;
        6'h04:   vector_of = `VEC_EXT;
        6'h08:   vector_of = `VEC_TMR0;
        6'h10:   vector_of = `VEC_TMR1;
        6'h20:   vector_of = `VEC_ADC;
        default: vector_of = `VEC_RESET;
      endcase
    end
  endfunction

  return_stack u_stack
  (
    .clk       (CLK),
    .reset     (RESET),
    .push      (push),
    .pop       (pop),
    .push_data (pc_q),
    .top_data  (stack_top),
    .full      (stack_full)
  );

  // Next counter, stack strobes and dummy decision, evaluated in the commit phase.
  always @*
  begin
    pc_d    = pc_q;
    dummy_d = 1'b0;
    push    = 1'b0;
    pop     = 1'b0;
    ack_d   = 6'h00;
    vec     = `VEC_RESET;
    if (phase_q == PH_EXEC)
    begin
      pc_d = pc_q + 11'h001;  // Advance past fetched word.
      if (!dummy_q && INSTR_VALID)
      begin
        case (OP)
          `OP_JUMP:
          begin
            pc_d    = OP_TARGET;
            dummy_d = 1'b1;
          end
          `OP_CALL:
          begin
            push    = 1'b1;  // Saved pc already points past the call.
            pc_d    = OP_TARGET;
            dummy_d = 1'b1;
          end
          `OP_RET:
          begin
            pop     = 1'b1;
            pc_d    = stack_top;
            dummy_d = 1'b1;
          end
          `OP_SKIP:
          begin
            dummy_d = SKIP_MET;  // Prefetch discarded when met.
          end
          `OP_TAB_CUR, `OP_TAB_FIN:
          begin
            dummy_d = 1'b1;  // Second cycle reads the table.
          end
          default:
          begin
            if (DATA_WE && DATA_ADDR == `ADDR_PCL)
            begin
              pc_d    = {pc_q[10:8], DATA_WDATA};  // Short jump in page.
              dummy_d = 1'b1;
            end
          end
        endcase
      end
      // Interrupt taken between instructions, only with a free level.
      if (!push && !pop && !dummy_d && !stack_full && INT_REQ != 6'h00)
      begin
        ack_d   = pick_lowest(INT_REQ);  // Held off while full.
        vec     = vector_of(ack_d);
        push    = 1'b1;
        pc_d    = vec;
        dummy_d = 1'b1;
      end
    end
  end

  // Phase counter, fetch, counter and lookup registers.
  always @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      phase_q      <= 2'h0;
      pc_q         <= `VEC_RESET;
      lookup_ptr_q <= 8'h00;
      lookup_hi_q  <= 6'h00;
      dummy_q      <= 1'b1;  // First slot holds no instruction yet.
      tab_pend_q   <= 1'b0;
      tab_addr_q   <= 11'h000;
      tab_dest_q   <= 8'h00;
      ROM_ADDR     <= `VEC_RESET;
      INSTR        <= 14'h0000;
      INSTR_VALID  <= 1'b0;
      PHASE        <= 2'h0;
      DATA_RDATA   <= 8'h00;
      TAB_WE       <= 1'b0;
      TAB_WADDR    <= 8'h00;
      TAB_WDATA    <= 8'h00;
      INT_ACK      <= 6'h00;
    end
    else
    begin
      phase_q <= phase_q + 2'h1;  // Four clocks per cycle.
      PHASE   <= phase_q + 2'h1;
      TAB_WE  <= 1'b0;
      INT_ACK <= 6'h00;
      // Register readback; the stack has no data address.
      case (DATA_ADDR)
        `ADDR_PCL:        DATA_RDATA <= pc_q[7:0];
        `ADDR_LOOKUP_PTR: DATA_RDATA <= lookup_ptr_q;
        `ADDR_LOOKUP_HI:  DATA_RDATA <= {2'b00, lookup_hi_q};
        default:          DATA_RDATA <= 8'h00;
      endcase
      // Of 07H and 08H, only the pointer accepts writes; 08H ignores them.
      if (DATA_WE && DATA_ADDR == `ADDR_LOOKUP_PTR && phase_q == PH_EXEC)
        lookup_ptr_q <= DATA_WDATA;
      // Address phase: a pending table read borrows the bus.
      if (phase_q == PH_FETCH)
        ROM_ADDR <= tab_pend_q ? tab_addr_q : pc_q;
      if (phase_q == 2'h2 && tab_pend_q)
      begin
        // Hand the bus back so the word after the lookup is fetched in time.
        ROM_ADDR    <= pc_q;
        TAB_WE      <= 1'b1;
        TAB_WADDR   <= tab_dest_q;
        TAB_WDATA   <= ROM_DATA[7:0];
        lookup_hi_q <= ROM_DATA[13:8];
        tab_pend_q  <= 1'b0;
      end
      if (phase_q == PH_EXEC)
      begin
        // The fetched word executes next unless this slot was redirected.
        INSTR       <= ROM_DATA;
        INSTR_VALID <= !dummy_d && !tab_pend_q;
        dummy_q     <= dummy_d;
        pc_q        <= dummy_d && ack_d == 6'h00 && !dummy_q && INSTR_VALID &&
                       (OP == `OP_TAB_CUR || OP == `OP_TAB_FIN)
                       ? pc_q : pc_d;
        INT_ACK     <= ack_d;
        if (!dummy_q && INSTR_VALID && ack_d == 6'h00 &&
            (OP == `OP_TAB_CUR || OP == `OP_TAB_FIN))
        begin
          tab_pend_q <= 1'b1;
          tab_dest_q <= TAB_DEST;
          tab_addr_q <= (OP == `OP_TAB_FIN) ? {`FINAL_PAGE, lookup_ptr_q}
                        : {pc_q[10:8], lookup_ptr_q};
        end
      end
    end
  end
endmodule
`default_nettype wire

// [rtl/seq_defines.vh]
// Purpose: Constants for the program sequencer, stack and table lookup.
// Assumes: Included by bare name from the sequencer design files.
// Notes:   Definitions only.
`ifndef SEQ_DEFINES_VH
`define SEQ_DEFINES_VH
`define ADDR_PCL        8'h06
`define ADDR_LOOKUP_PTR 8'h07
`define ADDR_LOOKUP_HI  8'h08
`define VEC_RESET       11'h000
`define VEC_CMP0        11'h004
`define VEC_CMP1        11'h008
`define VEC_EXT         11'h00C
`define VEC_TMR0        11'h010
`define VEC_TMR1        11'h014
`define VEC_ADC         11'h018
`define FINAL_PAGE      3'h7
`define STACK_DEPTH     8
`define PHASES          4
`define REQ_CMP0        0
`define REQ_CMP1        1
`define REQ_EXT         2
`define REQ_TMR0        3
`define REQ_TMR1        4
`define REQ_ADC         5
`define OP_NONE         3'h0
`define OP_JUMP         3'h1
`define OP_CALL         3'h2
`define OP_RET          3'h3
`define OP_SKIP         3'h4
`define OP_TAB_CUR      3'h5
`define OP_TAB_FIN      3'h6
`endif

// [rtl/return_stack.v]
// Purpose: Eight-level hardware return stack holding program counter copies.
// Assumes: Push and pop are one-cycle pulses, never both at once.
// Notes:   A push when full overwrites the oldest entry.
`include "seq_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module return_stack
(
  input  wire        clk,       // System clock.
  input  wire        reset,     // Asynchronous reset, active high.
  input  wire        push,      // Push request pulse.
  input  wire        pop,       // Pop request pulse.
  input  wire [10:0] push_data, // Program counter to save.
  output wire [10:0] top_data,  // Most recent saved value.
  output wire        full       // All eight levels hold entries.
);
  reg [10:0] mem_q [0:7];  // Entries; not visible to software.
  reg [2:0]  top_q;        // Index of next free slot, circular.
  reg [3:0]  count_q;      // Number of live entries, 0 to 8.
  integer    i;

  assign top_data = mem_q[top_q - 3'h1];
  assign full     = (count_q == 4'h8);

  // Circular storage lets an overflowing push drop the oldest entry for free.
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      top_q   <= 3'h0;  // Level pointer at the empty top.
      count_q <= 4'h0;
      for (i = 0; i < `STACK_DEPTH; i = i + 1)
        mem_q[i] <= 11'h000;
    end
    else if (push)
    begin
      mem_q[top_q] <= push_data;
      top_q        <= top_q + 3'h1;
      if (!full)
        count_q <= count_q + 4'h1;  // Full push keeps count, loses oldest.
    end
    else if (pop)
    begin
      if (count_q != 4'h0)
      begin
        top_q   <= top_q - 3'h1;
        count_q <= count_q - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// [sim/prog_rom_model.sv]
// Purpose: Program memory stand-in for the sequencer.
// Assumes: Combinational read of the addressed word.
// Notes:   Each word holds its own address, so fetches can be traced.
`timescale 1ns/1ps
`default_nettype none
module prog_rom_model
(
  input  wire logic [10:0] addr, // Fetch or lookup address.
  output var  logic [13:0] data  // Word at that address.
);
  // A fixed marker over the address fills all 14 bits of 2048 words.
  always_comb
  begin
    data = {3'h5, addr};
  end
endmodule
`default_nettype wire

// [sim/seq_chk.sv]
// Purpose: Port assertions for the program sequencer.
// Assumes: Bound to program_sequencer; one clock domain.
// Notes:   Requests count at the phase 3 edge of any slot that sets no dummy and has a free stack level, dummy slots included.
`include "seq_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module seq_chk
(
  input wire logic        CLK,         // Clock.
  input wire logic        RESET,       // Reset.
  input wire logic [2:0]  OP,          // Operation.
  input wire logic        SKIP_MET,    // Skip true.
  input wire logic [7:0]  TAB_DEST,    // Lookup target.
  input wire logic [7:0]  DATA_ADDR,   // Data address.
  input wire logic [5:0]  INT_REQ,     // Requests.
  input wire logic [10:0] ROM_ADDR,    // Fetch address.
  input wire logic        INSTR_VALID, // Slot valid.
  input wire logic [1:0]  PHASE,       // Phase.
  input wire logic [7:0]  DATA_RDATA,  // Read data.
  input wire logic        TAB_WE,      // Lookup write.
  input wire logic [7:0]  TAB_WADDR,   // Lookup address.
  input wire logic [5:0]  INT_ACK      // Acknowledge.
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);
  // Only a valid slot may act, so a dummy slot never triggers these checks.
  wire take = (PHASE == 2'h3) && INSTR_VALID;
  AST_PHASE: assert property (!$past(RESET) |-> PHASE == $past(PHASE) + 2'h1)
    else $error("phase did not advance");
  AST_XFER_DUMMY: assert property
    (take && OP == `OP_JUMP |-> ##[1:5] !INSTR_VALID) else $error("no dummy after jump");
  AST_SKIP_DUMMY: assert property
    (take && OP == `OP_SKIP && SKIP_MET |-> ##[1:5] !INSTR_VALID) else $error("no skip dummy");
  AST_RESET_PC: assert property ($fell(RESET) |-> ROM_ADDR == 11'h000)
    else $error("first fetch not from zero");
  AST_ACK_PRIO: assert property
    (INT_ACK != 6'h00 |-> $onehot(INT_ACK) && ($past(INT_REQ) & (INT_ACK - 6'h01)) == 6'h00
      && ($past(INT_REQ) & INT_ACK) != 6'h00) else $error("wrong interrupt acknowledged");
  AST_ACK_PULSE: assert property (INT_ACK != 6'h00 |=> INT_ACK == 6'h00)
    else $error("acknowledge too long");
  AST_TAB_DEST: assert property (TAB_WE |-> TAB_WADDR == TAB_DEST)
    else $error("lookup byte misdirected");
  AST_HI_ZERO: assert property (DATA_ADDR == 8'h08 |=> DATA_RDATA[7:6] == 2'h0)
    else $error("high result top bits set");
  C_CALL: cover property (take && OP == `OP_CALL);
  C_TAB: cover property (TAB_WE);
  C_ACK: cover property (INT_ACK != 6'h00);
endmodule
`default_nettype wire

// [sim/program_sequencer_stack_table_read_tb.sv]
// Purpose: Self-checking bench for the program sequencer.
// Assumes: Memory model words carry their own address.
// Notes:   INSTR therefore shows which address was executed.
`include "seq_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module program_sequencer_stack_table_read_tb;
  logic        CLK = 1'b0;
  logic        RESET = 1'b1;
  logic [2:0]  OP = 3'h0;
  logic [10:0] OP_TARGET = 11'h000;
  logic        SKIP_MET = 1'b0;
  logic [7:0]  TAB_DEST = 8'h33;   // Fixed so the checker can compare.
  logic [7:0]  DATA_ADDR = 8'h00;
  logic [7:0]  DATA_WDATA = 8'h00;
  logic        DATA_WE = 1'b0;
  logic [5:0]  INT_REQ = 6'h00;
  wire  [13:0] ROM_DATA;
  wire  [10:0] ROM_ADDR;
  wire  [13:0] INSTR;
  wire         INSTR_VALID;
  wire  [1:0]  PHASE;
  wire  [7:0]  DATA_RDATA;
  wire         TAB_WE;
  wire  [7:0]  TAB_WADDR;
  wire  [7:0]  TAB_WDATA;
  wire  [5:0]  INT_ACK;
  int          miscompares = 0;
  int          n_checks = 0;
  logic [10:0] cur;                // Address of the last driven slot.
  logic [10:0] ra [0:8];           // Expected return points.
  always #10 CLK = ~CLK;
  program_sequencer i_program_sequencer (.CLK, .RESET, .OP, .OP_TARGET, .SKIP_MET, .TAB_DEST,
    .DATA_ADDR, .DATA_WDATA, .DATA_WE, .INT_REQ, .ROM_DATA, .ROM_ADDR, .INSTR, .INSTR_VALID,
    .PHASE, .DATA_RDATA, .TAB_WE, .TAB_WADDR, .TAB_WDATA, .INT_ACK);
  prog_rom_model i_prog_rom_model (.addr(ROM_ADDR), .data(ROM_DATA));
  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic rst();
    @(posedge CLK);
    RESET <= 1'b1;
    repeat (2) @(posedge CLK);
    RESET <= 1'b0;
  endtask
  // Step to just after the phase 2 edge of the next valid slot.
  task automatic slot();
    int k;
    k = 0;
    @(posedge CLK);
    #1;
    while (!(PHASE === 2'h2 && INSTR_VALID === 1'b1) && k < 40)
    begin
      @(posedge CLK);
      #1;
      k++;
    end
  endtask
  // Drive one instruction; t[0] doubles as the skip condition, w = {we, addr, data}.
  task automatic ex(input logic [2:0] op, input logic [10:0] t, input logic [16:0] w);
    slot();
    cur = INSTR[10:0];
    @(posedge CLK);
    OP <= op;
    OP_TARGET <= t;
    SKIP_MET <= t[0];
    {DATA_WE, DATA_ADDR, DATA_WDATA} <= w;
    @(posedge CLK);
    OP <= `OP_NONE;
    DATA_WE <= 1'b0;
  endtask
  task automatic nx(input logic [10:0] e);
    slot();
    chk(INSTR, {3'h5, e});
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge CLK);
    DATA_ADDR <= a;
    @(posedge CLK);
    #1;
    chk(DATA_RDATA, e);
  endtask
  // Bounded waits: a lookup write, or any acknowledge.
  task automatic wt(input logic ack);
    int k;
    for (k = 0; k < 60 && (ack ? INT_ACK === 6'h00 : TAB_WE !== 1'b1); k++)
    begin
      @(posedge CLK);
      #1;
    end
  endtask
  task automatic t_flow();
    rst();
    slot();
    chk(INSTR, {3'h5, 11'h000});
    nx(11'h001);
    ex(`OP_JUMP, 11'h3A5, 17'h0);
    nx(11'h3A5);
    ex(`OP_SKIP, 11'h001, 17'h0);
    nx(cur + 11'h002);
    ex(`OP_SKIP, 11'h000, 17'h0);
    nx(cur + 11'h001);
    ex(`OP_NONE, 11'h000, 17'h10640);
    nx({cur[10:8], 8'h40});
  endtask
  task automatic t_table();
    ex(`OP_NONE, 11'h000, 17'h1075C);
    rd(8'h07, 8'h5C);
    ex(`OP_TAB_CUR, 11'h000, 17'h0);
    wt(1'b0);
    chk({TAB_WE, TAB_WDATA}, {1'b1, 8'h5C});
    rd(8'h08, {2'h0, 3'h5, cur[10:8]});
    ex(`OP_TAB_FIN, 11'h000, 17'h0);
    wt(1'b0);
    rd(8'h08, 8'h2F);
    ex(`OP_NONE, 11'h000, 17'h108FF);
    rd(8'h08, 8'h2F);
  endtask
  task automatic t_stack();
    int k;
    for (k = 0; k < 9; k++)
    begin
      ex(`OP_CALL, 11'h100 + k[10:0], 17'h0);
      ra[k] = cur + 11'h001;
    end
    for (k = 8; k > 0; k--)
    begin
      ex(`OP_RET, 11'h000, 17'h0);
      nx(ra[k]);
    end
  endtask
  task automatic t_irq();
    int k;
    int n;
    rst();
    @(posedge CLK);
    INT_REQ <= 6'h3F;
    for (k = 0; k < 6; k++)
    begin
      wt(1'b1);
      chk(INT_ACK, 6'h01 << k);
      @(posedge CLK);
      INT_REQ[k] <= 1'b0;
      for (n = 0; n < 8 && ROM_ADDR !== 11'h004 * (k + 1); n++)
      begin
        @(posedge CLK);
        #1;
      end
      chk(ROM_ADDR, 11'h004 * (k + 1));
    end
    ex(`OP_CALL, 11'h200, 17'h0);
    ex(`OP_CALL, 11'h240, 17'h0);
    INT_REQ <= 6'h01;
    n = 0;
    repeat (24)
    begin
      @(posedge CLK);
      #1;
      n += (INT_ACK !== 6'h00);
    end
    chk(n, 0);
    ex(`OP_RET, 11'h000, 17'h0);
    wt(1'b1);
    chk(INT_ACK, 6'h01);
  endtask
  initial
  begin
    t_flow();
    t_table();
    t_stack();
    t_irq();
    finish_test();
  end
  // The tests need well under 2000 clocks; 10000 means a hang.
  initial
  begin
    #200000;
    miscompares++;
    finish_test();
  end
endmodule
bind program_sequencer seq_chk i_seq_chk (.CLK, .RESET, .OP, .SKIP_MET, .TAB_DEST, .DATA_ADDR,
  .INT_REQ, .ROM_ADDR, .INSTR_VALID, .PHASE, .DATA_RDATA, .TAB_WE, .TAB_WADDR, .INT_ACK);
`default_nettype wire
